//--- common/fts_pkg.sv
// Constants shared by the frame timestamp unit
// Operation
// R01: Keep a free-running 32-bit timer as the local time base; with PERIOD_EN set the code instead wraps it at PERIOD, keeping the remainder.
// R02: Correction logic adjusts timer rate or value for master synchronization.
// R03: Optional interrupt each time a programmable timer period elapses.
// R04: Capture the timer when a received frame's start delimiter is detected.
// R05: Hand the receive timestamp to that frame's receive descriptor.
// R06: Timestamp every received frame, PTP or not; a delimiter arriving at a full FIFO is dropped and reported on RX_TS_LOST.
// R07: Driver flags PTP event frames for timestamping in the transmit descriptor.
// R08: Store flagged transmit frame timestamps in a dedicated register.
// R09: Raise an interrupt once a new transmit timestamp is stored.
// R10: Capture the transmit timestamp when the outgoing start delimiter is sent.
package fts_pkg;
  // ****************************************
  // Widths and FIFO depth
  // ****************************************
  localparam int FTS_TW = 32;
  localparam int FTS_INCW = 8;
  localparam int FTS_FIFO_DEPTH = 4;
  // ****************************************
  // Reset values and the constant one
  // ****************************************
  localparam logic [FTS_TW-1:0] FTS_TIMER_RST = 32'h0000_0000;
  localparam logic [FTS_TW-1:0] FTS_CORR_CNT_RST = 32'h0000_0000;
  localparam logic [FTS_TW-1:0] FTS_TX_TS_RST = 32'h0000_0000;
  localparam logic [FTS_TW-1:0] FTS_ONE = 32'h0000_0001;
endpackage

//--- common/fts_stream_if.sv
// Valid/ready word stream between the unit and its timestamp FIFO
`timescale 1ns/100ps
`default_nettype none
interface fts_stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // fts_stream_if
`default_nettype wire

//--- design/fts_fifo.sv
// Small shift-register FIFO; the head word always comes from a flip-flop
`timescale 1ns/100ps
`default_nettype none
module fts_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  fts_stream_if.snk wr,
  // Drain side
  fts_stream_if.src rd
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;

  assign wr.ready = (cnt_r != CNT_FULL);
  assign rd.valid = (cnt_r != '0);
  assign rd.data = mem_r[0];
  assign cnt_nxt = cnt_r + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);

  // ****************************************
  // Storage, one slot per entry
  // ****************************************
  // On a pop every entry moves one place toward the head, so a push lands one slot lower
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    localparam logic [CW-1:0] IDX = CW'(i);
    localparam logic [CW-1:0] IDX1 = CW'(i + 1);
    wire take_in = push && (pop ? (cnt_r == IDX1) : (cnt_r == IDX));
    if (i < DEPTH - 1) begin : g_mid
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_r[i] <= '0;
        end else if (take_in) begin
          mem_r[i] <= wr.data;
        end else if (pop) begin
          mem_r[i] <= mem_r[i+1];
        end
      end
    end else begin : g_last
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_r[i] <= '0;
        end else if (take_in) begin
          mem_r[i] <= wr.data;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  fifo_first_a: assert property (@(posedge clk) disable iff (rst) // R05
    (push && !rd.valid) |=> (rd.valid && rd.data == $past(wr.data)))
    else $error("word pushed into empty fifo not at head");
  fifo_full_a: assert property (@(posedge clk) disable iff (rst) // R06
    (cnt_r == CNT_FULL && !pop) |=> (cnt_r == CNT_FULL && $stable(rd.data)))
    else $error("full fifo changed without a pop");
endmodule // fts_fifo
`default_nettype wire

//--- design/fts_top.sv
// Frame timestamp unit: adjustable timer, period event, receive and transmit capture
`timescale 1ns/100ps
`default_nettype none
module fts_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Timer control
  input wire logic [fts_pkg::FTS_INCW-1:0] INC,
  input wire logic [fts_pkg::FTS_INCW-1:0] CORR_INC,
  input wire logic [fts_pkg::FTS_TW-1:0] CORR_PERIOD,
  input wire logic LOAD,
  input wire logic [fts_pkg::FTS_TW-1:0] LOAD_VAL,
  output logic [fts_pkg::FTS_TW-1:0] TIMER,
  // Period event
  input wire logic PERIOD_EN,
  input wire logic [fts_pkg::FTS_TW-1:0] PERIOD,
  input wire logic PERIOD_ACK,
  output logic PERIOD_IRQ,
  // Receive capture
  input wire logic RX_SFD,
  output logic RX_CAP_READY,
  output logic RX_TS_LOST,
  output logic RX_TS_VALID,
  input wire logic RX_TS_READY,
  output logic [fts_pkg::FTS_TW-1:0] RX_TS,
  // Transmit capture
  input wire logic TX_SFD,
  input wire logic TX_TS_REQ,
  input wire logic TX_TS_ACK,
  output logic [fts_pkg::FTS_TW-1:0] TX_TS,
  output logic TX_TS_IRQ
);
  import fts_pkg::*;

  logic [FTS_TW-1:0] timer_r;
  logic [FTS_TW-1:0] timer_nxt;
  logic [FTS_TW-1:0] corr_cnt_r;
  logic [FTS_TW-1:0] corr_cnt_nxt;
  logic period_irq_r;
  logic rx_lost_r;
  logic [FTS_TW-1:0] tx_ts_r;
  logic tx_irq_r;

  // ****************************************
  // Timer step and correction
  // ****************************************
  // A zero correction period turns correction off
  wire corr_on = (CORR_PERIOD != '0);
  wire corr_hit = corr_on && (corr_cnt_r == CORR_PERIOD - FTS_ONE); // R02
  wire [FTS_INCW-1:0] step = corr_hit ? CORR_INC : INC; // R02
  wire [FTS_TW:0] sum = {1'b0, timer_r} + {{(FTS_TW + 1 - FTS_INCW){1'b0}}, step}; // R01
  // Wrap at the period; the remainder is kept so no time is lost across the wrap
  wire wrap = PERIOD_EN && (sum >= {1'b0, PERIOD}); // R03
  wire [FTS_TW:0] sum_wrapped = sum - {1'b0, PERIOD};
  wire period_evt = wrap && !LOAD;

  assign corr_cnt_nxt = (!corr_on || corr_hit) ? FTS_CORR_CNT_RST : corr_cnt_r + FTS_ONE;
  assign timer_nxt = LOAD ? LOAD_VAL : (wrap ? sum_wrapped[FTS_TW-1:0] : sum[FTS_TW-1:0]); // R01 R02

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      timer_r <= FTS_TIMER_RST;
      corr_cnt_r <= FTS_CORR_CNT_RST;
    end else begin
      timer_r <= timer_nxt;
      corr_cnt_r <= corr_cnt_nxt;
    end
  end

  // Event wins over a simultaneous acknowledge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      period_irq_r <= 1'b0;
    end else begin
      period_irq_r <= period_evt || (period_irq_r && !PERIOD_ACK); // R03
    end
  end

  // ****************************************
  // Receive capture
  // ****************************************
  fts_stream_if #(.WIDTH(FTS_TW)) rx_fill ();
  fts_stream_if #(.WIDTH(FTS_TW)) rx_drain ();

  // Every start delimiter is offered, whatever the frame carries
  assign rx_fill.valid = RX_SFD; // R04 R06
  assign rx_fill.data = timer_r; // R04
  assign RX_CAP_READY = rx_fill.ready;
  assign RX_TS_VALID = rx_drain.valid; // R05
  assign RX_TS = rx_drain.data;
  assign rx_drain.ready = RX_TS_READY;

  fts_fifo #(.WIDTH(FTS_TW), .DEPTH(FTS_FIFO_DEPTH)) u_rx_fifo (
    .clk(CLK),
    .rst(RST),
    .wr(rx_fill),
    .rd(rx_drain)
  );

  // A delimiter cannot be held back, so a full FIFO drops it and says so
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_lost_r <= 1'b0;
    end else begin
      rx_lost_r <= RX_SFD && !rx_fill.ready;
    end
  end

  // ****************************************
  // Transmit capture
  // ****************************************
  wire tx_cap = TX_SFD && TX_TS_REQ; // R07 R10

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_ts_r <= FTS_TX_TS_RST;
    end else if (tx_cap) begin
      tx_ts_r <= timer_r; // R08 R10
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_irq_r <= 1'b0;
    end else begin
      tx_irq_r <= tx_cap || (tx_irq_r && !TX_TS_ACK); // R09
    end
  end

  assign TIMER = timer_r;
  assign PERIOD_IRQ = period_irq_r;
  assign RX_TS_LOST = rx_lost_r;
  assign TX_TS = tx_ts_r;
  assign TX_TS_IRQ = tx_irq_r;

  // ****************************************
  // Checks: timer and period
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // The remainder check catches a wrap that drops the overshoot
  sequence wrap_taken_s;
    period_evt;
  endsequence
  sequence wrap_rest_s;
    TIMER == $past(TIMER) + FTS_TW'($past(step)) - $past(PERIOD);
  endsequence

  timer_step_a: assert property ((!LOAD && !wrap) |=> // R01
    TIMER == $past(TIMER) + FTS_TW'($past(step)))
    else $error("timer did not advance by its step");

  corr_step_a: assert property ((corr_hit && !LOAD && !wrap) |=> // R02
    TIMER == $past(TIMER) + FTS_TW'($past(CORR_INC)))
    else $error("correction step not applied");

  // Correction off must fall back to the plain step, never to CORR_INC
  corr_off_a: assert property ((!corr_on && !LOAD && !wrap) |=> // R02
    TIMER == $past(TIMER) + FTS_TW'($past(INC)))
    else $error("plain step not used with correction off");

  timer_load_a: assert property (LOAD |=> TIMER == $past(LOAD_VAL)) // R02
    else $error("timer load ignored");

  period_wrap_a: assert property (period_evt |=> PERIOD_IRQ && (TIMER < $past(PERIOD))) // R03
    else $error("period elapse not flagged or not wrapped");

  period_rest_a: assert property (wrap_taken_s |=> wrap_rest_s) // R03
    else $error("remainder lost across the period wrap");

  period_hold_a: assert property ((PERIOD_IRQ && !PERIOD_ACK) |=> PERIOD_IRQ) // R03
    else $error("period flag dropped without acknowledge");

  period_clear_a: assert property ((PERIOD_IRQ && PERIOD_ACK && !period_evt) |=> !PERIOD_IRQ) // R03
    else $error("period flag not cleared by acknowledge");

  period_quiet_a: assert property ((!period_evt && !PERIOD_IRQ) |=> !PERIOD_IRQ) // R03
    else $error("period flag raised without an elapse");

  // ****************************************
  // Checks: receive
  // ****************************************
  rx_capture_a: assert property ((RX_SFD && RX_CAP_READY) |=> RX_TS_VALID) // R04
    else $error("received frame timestamp not queued");

  rx_lost_a: assert property ((RX_SFD && !RX_CAP_READY) |=> RX_TS_LOST) // R06
    else $error("dropped receive timestamp not reported");

  rx_lost_once_a: assert property (!RX_SFD |=> !RX_TS_LOST) // R06
    else $error("loss reported without a delimiter");

  // The descriptor writer may stall; the head word must not move under it
  rx_hold_a: assert property ((RX_TS_VALID && !RX_TS_READY) |=> (RX_TS_VALID && $stable(RX_TS))) // R05
    else $error("receive head word changed before it was taken");

  rx_full_a: assert property ((RX_TS_VALID && !RX_CAP_READY && !RX_TS_READY) |=> !RX_CAP_READY) // R06
    else $error("full receive queue freed without a pop");

  // ****************************************
  // Checks: transmit
  // ****************************************
  sequence tx_capture_s;
    TX_SFD && TX_TS_REQ;
  endsequence
  sequence tx_report_s;
    (TX_TS == $past(TIMER)) && TX_TS_IRQ;
  endsequence

  tx_report_a: assert property (tx_capture_s |=> tx_report_s) // R08
    else $error("transmit timestamp not stored or not flagged");

  tx_quiet_a: assert property ((!tx_cap && !TX_TS_IRQ) |=> !TX_TS_IRQ) // R09
    else $error("transmit flag raised without a capture");

  // An unflagged delimiter leaves the last stamp for software to read
  tx_hold_a: assert property (!tx_cap |=> $stable(TX_TS)) // R08
    else $error("transmit stamp changed without a capture");

  tx_clear_a: assert property ((TX_TS_IRQ && TX_TS_ACK && !tx_cap) |=> !TX_TS_IRQ) // R09
    else $error("transmit flag not cleared by acknowledge");
endmodule // fts_top
`default_nettype wire

//--- verification/fts_net_model.sv
// Far-side model: delimiter source and receive descriptor writer
`timescale 1ns/100ps
`default_nettype none
module fts_net_model (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic send_rx,
  input wire logic send_tx,
  input wire logic want_ts,
  input wire logic drain,
  input wire logic slow,
  // Toward the unit
  output logic rx_sfd,
  output logic tx_sfd,
  output logic tx_req,
  output logic rx_ready
);
  logic stall_r = 1'b0;
  // Slow writer skips every other cycle so the queue backs up
  always_ff @(posedge clk) begin
    stall_r <= slow & ~stall_r;
  end
  assign rx_sfd = send_rx;
  assign tx_sfd = send_tx;
  assign tx_req = send_tx & want_ts;
  assign rx_ready = drain & ~stall_r;
endmodule // fts_net_model
`default_nettype wire

//--- verification/fts_top_tb_top.sv
// Self-checking bench for the frame timestamp unit
`timescale 1ns/100ps
`default_nettype none
module fts_top_tb_top;
  import fts_pkg::*;
  logic CLK = 0, RST = 1, LOAD = 0, PERIOD_EN = 0, PERIOD_ACK = 0, TX_TS_ACK = 0;
  logic send_rx = 0, send_tx = 0, want_ts = 0, drain = 0, slow = 0;
  logic [FTS_INCW-1:0] INC = 8'h01, CORR_INC = 8'h01;
  logic [FTS_TW-1:0] CORR_PERIOD = 32'h4, LOAD_VAL = 32'h0, PERIOD = 32'h64, t;
  logic [FTS_TW-1:0] TIMER, RX_TS, TX_TS;
  logic RX_SFD, RX_CAP_READY, RX_TS_LOST, RX_TS_VALID, RX_TS_READY, TX_SFD, TX_TS_REQ, PERIOD_IRQ, TX_TS_IRQ;
  logic [FTS_TW-1:0] q[$];
  int fails = 0, n_tests = 0;
  // Rows: step, load value and the value one step later; the second row wraps past 2^32
  logic [FTS_INCW-1:0] r_inc [3] = '{8'h01, 8'hff, 8'h05};
  logic [FTS_TW-1:0] r_val [3] = '{32'h0, 32'hffff_fff0, 32'h1234_5678};
  logic [FTS_TW-1:0] r_exp [3] = '{32'h0000_0001, 32'h0000_00ef, 32'h1234_567d};
  // Flags: capture ready, valid, lost, period irq, transmit irq
  wire logic [FTS_TW-1:0] fl = {27'h0, RX_CAP_READY, RX_TS_VALID, RX_TS_LOST, PERIOD_IRQ, TX_TS_IRQ};

  fts_top u_fts_top (.CLK, .RST, .INC, .CORR_INC, .CORR_PERIOD, .LOAD, .LOAD_VAL, .TIMER, .PERIOD_EN,
    .PERIOD, .PERIOD_ACK, .PERIOD_IRQ, .RX_SFD, .RX_CAP_READY, .RX_TS_LOST, .RX_TS_VALID, .RX_TS_READY,
    .RX_TS, .TX_SFD, .TX_TS_REQ, .TX_TS_ACK, .TX_TS, .TX_TS_IRQ);
  fts_net_model u_fts_net_model (.clk(CLK), .send_rx(send_rx), .send_tx(send_tx), .want_ts(want_ts),
    .drain(drain), .slow(slow), .rx_sfd(RX_SFD), .tx_sfd(TX_SFD), .tx_req(TX_TS_REQ), .rx_ready(RX_TS_READY));

  always #5 CLK = ~CLK;

  task automatic chk(input logic [FTS_TW-1:0] seen, input logic [FTS_TW-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ld(input logic [FTS_TW-1:0] v);
    @(negedge CLK);
    LOAD = 1;
    LOAD_VAL = v;
    @(negedge CLK);
    LOAD = 0;
  endtask

  task automatic close_out;
    $display("counts: %0d checks, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run is about 80 cycles; the 2000-cycle limit leaves ample margin
  initial begin
    #(2000 * 10);
    fails++;
    close_out();
  end

  initial begin
    repeat (16) @(negedge CLK);
    chk(fl, 32'h10);
    RST = 0;
    chk(TIMER, FTS_TIMER_RST);
    chk(TX_TS, FTS_TX_TS_RST);
    $display("test reset done");
    // ****************************************
    // Step and load table
    // ****************************************
    foreach (r_inc[i]) begin
      INC = r_inc[i];
      CORR_INC = r_inc[i];
      ld(r_val[i]);
      chk(TIMER, r_val[i]);
      @(negedge CLK);
      chk(TIMER, r_exp[i]);
    end
    $display("test table done");
    // Eight cycles hold exactly two correction steps
    INC = 8'h01;
    CORR_INC = 8'h03;
    t = TIMER;
    repeat (8) @(negedge CLK);
    chk(TIMER, t + 32'd12);
    $display("test correction done");
    // A zero correction period leaves only the plain step
    CORR_PERIOD = 32'h0;
    t = TIMER;
    repeat (8) @(negedge CLK);
    chk(TIMER, t + 32'd8);
    $display("test correction off done");
    INC = 8'h07;
    CORR_INC = 8'h07;
    ld(32'd95);
    PERIOD_EN = 1;
    @(negedge CLK);
    chk(TIMER, 32'd2);
    chk(fl, 32'h12);
    PERIOD_ACK = 1;
    @(negedge CLK);
    chk(fl, 32'h10);
    // Acknowledge held through a fresh elapse: the new event wins
    ld(32'd95);
    @(negedge CLK);
    chk(TIMER, 32'd2);
    chk(fl, 32'h12);
    @(negedge CLK);
    chk(fl, 32'h10);
    PERIOD_ACK = 0;
    PERIOD_EN = 0;
    INC = 8'h01;
    CORR_INC = 8'h01;
    $display("test period done");
    // ****************************************
    // Receive: fill past four, then drain slowly
    // ****************************************
    for (int i = 0; i < 5; i++) begin
      @(negedge CLK);
      if (i < 4) q.push_back(TIMER);
      else chk(fl, 32'h08);
      send_rx = 1;
    end
    @(negedge CLK);
    send_rx = 0;
    chk(fl, 32'h0c);
    drain = 1;
    slow = 1;
    // Look once the writer's ready has settled, at the word the coming edge takes
    for (int k = 0; k < 20; k++) begin
      #1;
      if (RX_TS_VALID === 1'b1 && RX_TS_READY === 1'b1) chk(RX_TS, q.pop_front());
      @(negedge CLK);
    end
    chk(q.size(), 32'h0);
    chk(fl, 32'h10);
    $display("test receive done");
    // ****************************************
    // Transmit: unflagged, flagged, overwrite, set beats clear
    // ****************************************
    send_tx = 1;
    @(negedge CLK);
    chk(fl, 32'h10);
    chk(TX_TS, FTS_TX_TS_RST);
    t = TIMER;
    want_ts = 1;
    @(negedge CLK);
    chk(TX_TS, t);
    chk(fl, 32'h11);
    t = TIMER;
    TX_TS_ACK = 1;
    @(negedge CLK);
    chk(TX_TS, t);
    chk(fl, 32'h11);
    send_tx = 0;
    want_ts = 0;
    @(negedge CLK);
    chk(fl, 32'h10);
    TX_TS_ACK = 0;
    $display("test transmit done");
    // Reset in mid-run: timer and stored stamps go back to their reset values
    RST = 1;
    @(negedge CLK);
    chk(TIMER, FTS_TIMER_RST);
    chk(TX_TS, FTS_TX_TS_RST);
    chk(RX_TS, 32'h0);
    chk(fl, 32'h10);
    RST = 0;
    @(negedge CLK);
    chk(TIMER, FTS_TIMER_RST + {24'h0, INC});
    $display("test reset in mid-run done");
    close_out();
  end
endmodule // fts_top_tb_top
`default_nettype wire
